// *** hw/uarx_pkg.sv ***
package uarx_pkg;

   // ==========================================================
   // Register map (byte addresses, one 32-bit word each)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0c;

   // ==========================================================
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_U2X_BIT = 1;
   localparam int CTRL_PAR_BIT = 2;
   localparam int CTRL_ODD_BIT = 3;
   localparam int CTRL_SIZE_LSB = 4;
   localparam int STAT_RXC_BIT = 0;
   localparam int STAT_FE_BIT = 1;
   localparam int STAT_PE_BIT = 2;
   localparam int STAT_OVR_BIT = 3;

   // ==========================================================
   // Sampling figures and reset values
   localparam logic [4:0] SMP_PER_BIT_NORMAL = 5'h10;
   localparam logic [4:0] SMP_PER_BIT_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
   localparam logic [4:0] VOTE_SPAN = 5'h02;
   localparam logic [3:0] DATA_BITS_MIN = 4'h5;
   localparam logic [11:0] BAUD_DIV_RESET = 12'h014;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_BITS,
      RX_STOP
   } uarx_rx_e;

   typedef struct packed {
      logic [1:0] size;
      logic odd;
      logic par;
      logic u2x;
      logic en;
   } uarx_ctrl_s;

   typedef struct packed {
      logic [7:0] data;
      logic fe;
      logic pe;
   } uarx_entry_s;

   typedef struct packed {
      uarx_ctrl_s ctrl;
      logic [11:0] divisor;
      logic [11:0] div_cnt;
      logic tick;
      logic rx_s1;
      logic rx_s2;
      logic last_smp;
      uarx_rx_e st;
      logic [4:0] cnt;
      logic [2:0] votes;
      logic [3:0] bitidx;
      logic [7:0] shreg;
      logic perr;
      uarx_entry_s [1:0] fifo;
      logic head;
      logic [1:0] count;
      logic overrun;
      logic ack;
      logic [31:0] rdat;
      logic claim;
   } uarx_state_s;

endpackage

// *** hw/uarx_receiver.sv ***
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE_01) Parity error flag set only for failed parity with parity checking enabled.
// (RULE_02) Parity error flag follows the head character until the data buffer is read.
// (RULE_03) Clearing receiver enable stops reception at once, dropping the current frame.
// (RULE_04) Receiver releases the receive pin to its port function while disabled.
// (RULE_05) Disabling empties the receive buffer so receive complete reads zero.
// (RULE_06) Software flushes during operation by reading data until receive complete clears.
// (RULE_07) Line sampled 16 times per bit normally, 8 times in double speed.
// (RULE_08) Falling edge on idle line starts detection; first low sample is one.
// (RULE_09) Start bit checked on samples 8,9,10 normally, 4,5,6 in double speed.
// (RULE_10) Two or more high check samples reject the start as noise.
// (RULE_11) Valid start bit resynchronises bit timing, again at every start bit.
// (RULE_12) Per-bit sample machine has 16 states normally, 8 in double speed.
// (RULE_13) Bit value is the majority of the three centre samples.
// (RULE_14) Recovery covers data, optional parity and first stop bit only.
// (RULE_15) First stop bit voted; zero sets the framing error flag.
// (RULE_16) New falling edge accepted right after stop voting; later in double speed.
// (RULE_17) Vote timing keeps tolerance for 5 to 10 data plus parity bits; here at most 8 data plus parity, so 9.
// (RULE_18) Remote transmitter keeps its bit rate inside the acceptance window.
// (RULE_19) Receive complete is one while unread characters remain, else zero.
// (RULE_20) Receive buffer holds two characters with their error status bits.
// (RULE_21) Sample counter idles between frames and restarts at each falling edge.

module uarx_receiver #(
   parameter int BAUD_DIV_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial line
   input wire logic rx_i,
   output logic rx_claim_o
);

   // ==========================================================
   // Helpers
   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   uarx_pkg::uarx_state_s q;
   uarx_pkg::uarx_state_s n;

   logic req;
   logic [4:0] smp_total;
   logic [4:0] vote_first;
   logic [4:0] vote_last;
   logic [4:0] stop_done;
   logic [3:0] data_bits;
   logic [3:0] bits_total;
   logic vote;
   logic push;
   logic pop;
   logic wr_idx;
   uarx_pkg::uarx_entry_s new_entry;
   uarx_pkg::uarx_entry_s head_entry;

   // ==========================================================
   // Next state
   always_comb begin
      n = q;
      n.ack = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      new_entry = '0;
      req = wb_cyc_i & wb_stb_i & ~q.ack;
      head_entry = q.fifo[q.head];

      // Sample tick divider; all slower rates are one-cycle enables
      if (q.div_cnt >= q.divisor[11:0]) begin
         n.div_cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.div_cnt = q.div_cnt + 12'h001;
         n.tick = 1'b0;
      end

      // Pin synchroniser
      n.rx_s1 = rx_i;
      n.rx_s2 = q.rx_s1;

      smp_total = q.ctrl.u2x ? uarx_pkg::SMP_PER_BIT_DOUBLE
                             : uarx_pkg::SMP_PER_BIT_NORMAL; // [RULE_07] [RULE_12]
      vote_first = q.ctrl.u2x ? uarx_pkg::VOTE_FIRST_DOUBLE
                              : uarx_pkg::VOTE_FIRST_NORMAL; // [RULE_09] [RULE_17]
      vote_last = vote_first + uarx_pkg::VOTE_SPAN;
      // Double speed holds one extra sample before a new edge may count
      stop_done = vote_last + {4'h0, q.ctrl.u2x}; // [RULE_16]
      data_bits = uarx_pkg::DATA_BITS_MIN + {2'b00, q.ctrl.size};
      bits_total = data_bits + {3'b000, q.ctrl.par};
      vote = majority({q.votes[1:0], q.rx_s2}); // [RULE_13]

      if (!q.ctrl.en) begin
         // Disabled: frame dropped, counter parked, buffer flushed
         n.st = uarx_pkg::RX_IDLE; // [RULE_03]
         n.cnt = '0; // [RULE_21]
         n.last_smp = 1'b1;
         n.count = 2'b00; // [RULE_05]
         n.overrun = 1'b0;
      end else if (q.tick) begin
         n.last_smp = q.rx_s2;
         unique case (q.st)
            uarx_pkg::RX_IDLE: begin
               n.cnt = '0; // [RULE_21]
               if (q.last_smp && !q.rx_s2) begin
                  n.st = uarx_pkg::RX_START; // [RULE_08]
                  // This tick holds sample one, so the count names the next sample
                  n.cnt = 5'h02; // [RULE_21]
                  n.votes = '0;
                  n.bitidx = '0;
                  n.shreg = '0;
                  n.perr = 1'b0;
               end
            end
            uarx_pkg::RX_START, uarx_pkg::RX_BITS: begin
               n.cnt = q.cnt + 5'h01; // [RULE_12]
               if (q.cnt >= vote_first && q.cnt <= vote_last) begin
                  n.votes = {q.votes[1:0], q.rx_s2};
               end
               if (q.cnt == vote_last) begin
                  if (q.st == uarx_pkg::RX_START) begin
                     if (vote) begin
                        n.st = uarx_pkg::RX_IDLE; // [RULE_10]
                        n.cnt = '0;
                     end
                  end else begin
                     if (q.bitidx < data_bits) begin
                        n.shreg[q.bitidx[2:0]] = vote; // [RULE_13]
                     end else begin
                        n.perr = (^q.shreg) ^ vote ^ q.ctrl.odd;
                     end
                     n.bitidx = q.bitidx + 4'h1; // [RULE_14]
                  end
               end
               if (q.cnt == smp_total) begin
                  n.cnt = 5'h01;
                  if (q.st == uarx_pkg::RX_START) begin
                     // Bit timing now locked to this start bit
                     n.st = uarx_pkg::RX_BITS; // [RULE_11]
                  end else if (q.bitidx == bits_total) begin
                     n.st = uarx_pkg::RX_STOP; // [RULE_14]
                  end
               end
            end
            uarx_pkg::RX_STOP: begin
               n.cnt = q.cnt + 5'h01;
               if (q.cnt >= vote_first && q.cnt <= vote_last) begin
                  n.votes = {q.votes[1:0], q.rx_s2};
               end
               if (q.cnt == vote_last) begin
                  push = 1'b1;
                  new_entry.data = q.shreg;
                  new_entry.fe = ~vote; // [RULE_15]
                  new_entry.pe = q.ctrl.par & q.perr; // [RULE_01]
               end
               // Further stop bits are never looked at
               if (q.cnt == stop_done) begin
                  n.st = uarx_pkg::RX_IDLE; // [RULE_14] [RULE_16]
                  n.cnt = '0; // [RULE_21]
               end
            end
         endcase
      end

      // Register bus
      if (req) begin
         n.ack = 1'b1;
         n.rdat = '0;
         if (wb_we_i) begin
            if (wb_adr_i == uarx_pkg::ADDR_CTRL && wb_sel_i[0]) begin
               n.ctrl = uarx_pkg::uarx_ctrl_s'(wb_dat_i[5:0]);
            end
            if (wb_adr_i == uarx_pkg::ADDR_BAUD) begin
               if (wb_sel_i[0]) begin
                  n.divisor[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  n.divisor[11:8] = wb_dat_i[11:8];
               end
            end
         end else begin
            unique case (wb_adr_i)
               uarx_pkg::ADDR_CTRL: n.rdat[5:0] = q.ctrl;
               uarx_pkg::ADDR_BAUD: n.rdat[11:0] = q.divisor;
               uarx_pkg::ADDR_STAT: begin
                  n.rdat[uarx_pkg::STAT_RXC_BIT] = (q.count != 2'b00); // [RULE_19]
                  // Frame and parity error bits belong to the character at the read position; overrun is a buffer-wide flag
                  n.rdat[uarx_pkg::STAT_FE_BIT] = (q.count != 2'b00) & head_entry.fe;
                  n.rdat[uarx_pkg::STAT_PE_BIT] = (q.count != 2'b00) & head_entry.pe; // [RULE_02]
                  n.rdat[uarx_pkg::STAT_OVR_BIT] = q.overrun;
               end
               uarx_pkg::ADDR_DATA: begin
                  if (q.count != 2'b00) begin
                     n.rdat[7:0] = head_entry.data;
                     pop = 1'b1; // [RULE_02]
                  end
               end
               default: n.rdat = '0;
            endcase
         end
      end

      // Two-entry receive buffer; a frame finding it full is dropped unless a data read frees a slot in that cycle
      wr_idx = q.head ^ q.count[0];
      if (q.ctrl.en) begin
         if (push && (q.count != 2'b10 || pop)) begin
            n.fifo[wr_idx] = new_entry; // [RULE_20]
            n.overrun = 1'b0;
         end else if (push) begin
            n.overrun = 1'b1;
         end
         if (pop) begin
            n.head = ~q.head;
         end
         if (push && !pop && q.count != 2'b10) begin
            n.count = q.count + 2'b01; // [RULE_19]
         end else if (pop && !push) begin
            n.count = q.count - 2'b01; // [RULE_19]
         end
      end

      n.claim = q.ctrl.en; // [RULE_04]
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.ctrl <= uarx_pkg::uarx_ctrl_s'(uarx_pkg::CTRL_RESET);
         q.divisor <= uarx_pkg::BAUD_DIV_RESET;
         q.rx_s1 <= 1'b1;
         q.rx_s2 <= 1'b1;
         q.last_smp <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign rx_claim_o = q.claim;

endmodule
`default_nettype wire

// *** testbench/uarx_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====
// Remote transmitter: drives frames at an exact bit rate, idle high
module uarx_tx_model (
   // Clock
   input wire logic clk_i,
   // Line
   output logic line_o
);
   initial line_o = 1'b1;
   task automatic bit_out(input logic b, input int n);
      repeat (n) @(posedge clk_i) line_o <= b;
   endtask
   task automatic send(input logic [7:0] d, input int nb, input logic pen,
                       input logic odd, input logic pbad, input logic stp, input int spb);
      logic [7:0] m;
      m = 8'hff >> (8 - nb);
      bit_out(1'b0, spb);
      for (int i = 0; i < nb; i++) bit_out(d[i], spb);
      if (pen) bit_out(^(d & m) ^ odd ^ pbad, spb);
      bit_out(stp, spb);
      bit_out(1'b1, spb);
   endtask
   task automatic glitch(input int n);
      bit_out(1'b0, n);
      bit_out(1'b1, 24);
   endtask
endmodule
`default_nettype wire

// *** testbench/uarx_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module uarx_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Line
   input wire logic rx_i,
   input wire logic rx_claim_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req, wctl, off;
   assign req = wb_cyc_i & wb_stb_i & !wb_ack_o;
   assign wctl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == uarx_pkg::ADDR_CTRL);
   // =====
   // Tracks whether software has the receiver switched off
   always_ff @(posedge clk_i) begin
      if (rst_i) off <= 1'b1;
      else if (wctl) off <= !wb_dat_i[0];
   end
   sequence rd_of(logic [7:0] a);
      req && !wb_we_i && wb_adr_i == a;
   endsequence
   ack_latency_a: assert property (req |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
   claim_on_a: assert property (wctl && wb_dat_i[0] |-> ##[1:3] rx_claim_o)
      else $error("pin not claimed");
   claim_off_a: assert property (wctl && !wb_dat_i[0] |-> ##[1:3] !rx_claim_o)
      else $error("pin not released");
   claim_hold_a: assert property (off && $past(off, 2) |-> !rx_claim_o)
      else $error("pin held while off");
   flush_stat_a: assert property (off ##0 rd_of(uarx_pkg::ADDR_STAT) |=> !wb_dat_o[0])
      else $error("data while off");
   flush_data_a: assert property (off ##0 rd_of(uarx_pkg::ADDR_DATA) |=> wb_dat_o == 32'h0)
      else $error("char while off");
   err_empty_a: assert property (rd_of(uarx_pkg::ADDR_STAT) ##1 !wb_dat_o[0] |->
      wb_dat_o[2:1] == 2'h0) else $error("flags on empty");
endmodule
bind uarx_receiver uarx_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_i, .rx_claim_o);
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_i, rx_claim_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   int bad_count = 0;
   int checks_done = 0;
   localparam logic [7:0] CT = uarx_pkg::ADDR_CTRL;
   localparam logic [7:0] ST = uarx_pkg::ADDR_STAT;
   localparam logic [7:0] DA = uarx_pkg::ADDR_DATA;
   uarx_receiver DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_i, .rx_claim_o);
   uarx_tx_model u_tx (.clk_i(clk_i), .line_o(rx_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // =====
   // Shared tasks
   task automatic give_verdict;
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %0t got %h want %h", $time, g, e);
      end
   endtask
   // Holds the request until ack is sampled, then releases it
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 40) begin
         bad_count++;
         give_verdict;
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(q, e);
   endtask
   // =====
   // Scenarios
   task automatic s_reset;
      rc(CT, 32'h0);
      rc(uarx_pkg::ADDR_BAUD, 32'h14);
      rc(ST, 32'h0);
      rc(8'h10, 32'h0);
      bus(uarx_pkg::ADDR_BAUD, 1'b1, 32'h0);
   endtask
   task automatic s_modes;
      bus(CT, 1'b1, 32'h31);
      u_tx.send(8'ha5, 8, 0, 0, 0, 1, 16);
      rc(ST, 32'h1);
      rc(DA, 32'ha5);
      rc(ST, 32'h0);
      bus(CT, 1'b1, 32'h33);
      u_tx.send(8'h3c, 8, 0, 0, 0, 1, 8);
      rc(DA, 32'h3c);
      bus(CT, 1'b1, 32'h01);
      u_tx.send(8'h15, 5, 0, 0, 0, 1, 16);
      rc(DA, 32'h15);
   endtask
   task automatic s_parity;
      bus(CT, 1'b1, 32'h35);
      u_tx.send(8'h5a, 8, 1, 0, 0, 1, 16);
      u_tx.send(8'h5b, 8, 1, 0, 1, 1, 16);
      rc(ST, 32'h1);
      rc(DA, 32'h5a);
      rc(ST, 32'h5);
      rc(DA, 32'h5b);
      bus(CT, 1'b1, 32'h3d);
      u_tx.send(8'h5a, 8, 1, 1, 0, 1, 16);
      rc(ST, 32'h1);
      rc(DA, 32'h5a);
      bus(CT, 1'b1, 32'h21);
      u_tx.send(8'h03, 7, 1, 0, 1, 1, 16);
      rc(ST, 32'h1);
      rc(DA, 32'h03);
   endtask
   task automatic s_errors;
      int n;
      bus(CT, 1'b1, 32'h31);
      u_tx.send(8'h81, 8, 0, 0, 0, 0, 16);
      rc(ST, 32'h3);
      rc(DA, 32'h81);
      u_tx.glitch(5);
      rc(ST, 32'h0);
      u_tx.send(8'h11, 8, 0, 0, 0, 1, 16);
      u_tx.send(8'h22, 8, 0, 0, 0, 1, 16);
      n = 0;
      for (int i = 0; i < 4; i++) begin
         bus(ST, 1'b0, 32'h0);
         if (q[0] === 1'b1) begin
            bus(DA, 1'b0, 32'h0);
            n++;
         end
      end
      chk(n, 2);
      u_tx.send(8'h11, 8, 0, 0, 0, 1, 16);
      u_tx.send(8'h22, 8, 0, 0, 0, 1, 16);
      u_tx.send(8'h33, 8, 0, 0, 0, 1, 16);
      rc(ST, 32'h9);
      rc(DA, 32'h11);
      rc(DA, 32'h22);
      rc(ST, 32'h8);
   endtask
   task automatic s_disable;
      u_tx.send(8'h44, 8, 0, 0, 0, 1, 16);
      bus(CT, 1'b1, 32'h30);
      rc(ST, 32'h0);
      chk(rx_claim_o, 1'b0);
      bus(CT, 1'b1, 32'h31);
      fork
         u_tx.send(8'h0f, 8, 0, 0, 0, 1, 16);
         begin
            repeat (70) @(posedge clk_i);
            bus(CT, 1'b1, 32'h30);
         end
      join
      bus(CT, 1'b1, 32'h31);
      rc(ST, 32'h0);
      chk(rx_claim_o, 1'b1);
   endtask
   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset;
      s_modes;
      s_parity;
      s_errors;
      s_disable;
      give_verdict;
   end
endmodule
`default_nettype wire
